// ===== design/hbp_parser.sv
// Hex/binary and secure message field parser with character output FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module hbp_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wrPtr_ff;
  logic [AW:0]      rdPtr_ff;
  wire              full  = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
  wire              empty = wrPtr_ff == rdPtr_ff;
  wire              doWr  = inValid & ~full;
  wire              doRd  = outReady & ~empty;

  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = mem_ff[rdPtr_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doWr) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (doRd) rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end

  // Storage needs no reset; empty flag guards the read data
  always_ff @(posedge clk) begin
    if (doWr) mem_ff[wrPtr_ff[AW-1:0]] <= inData;
  end
endmodule

////////////////////////////////////////////////////////////////////////
module hbp_parser #(
  parameter logic [2:0] SEC_TYPE = 3'h7,
  parameter int         DEPTH    = hbp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Codewords from the channel
  input  wire logic                  cwValid,
  output logic                       cwReady,
  input  wire logic [20:0]           cwData,
  input  wire logic [2:0]            cwType,
  input  wire logic                  cwStart,
  input  wire logic                  cwLast,
  // Decoded fields
  output hbp_pkg::hbp_hdr_type       hdr,
  output hbp_pkg::hbp_info_type      info,
  output logic                       hdrStrobe,
  output logic                       infoStrobe,
  output logic                       msgDone,
  output logic                       sigError,
  output logic                       fragError,
  output logic                       expectMore,
  // Characters to the message store
  output logic                       chValid,
  input  wire logic                  chReady,
  output hbp_pkg::hbp_char_type      chData
);
  // Last valid data position plus one; zero for an all-fill word
  function automatic logic [4:0] fillEnd(input logic [20:0] w);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 0; i < hbp_pkg::CW_BITS; i++) begin
      if (w[i] != w[20]) p = 5'(i + 1);
    end
    return p;
  endfunction

  function automatic logic [4:0] blkLen(input logic [3:0] b);
    return (b == 4'h0) ? 5'h10 : {1'b0, b};
  endfunction

  hbp_pkg::hbp_state_type state_ff;
  hbp_pkg::hbp_hdr_type   hdr_ff;
  hbp_pkg::hbp_info_type  info_ff;
  logic [20:0] word_ff;
  logic [4:0]  limit_ff;
  logic [4:0]  bitIdx_ff;
  logic        last_ff;
  logic        secure_ff;
  logic [1:0]  wordIdx_ff;
  logic        firstFrag_ff;
  logic        more_ff;
  logic [1:0]  expFrag_ff;
  logic [15:0] charAcc_ff;
  logic [3:0]  charBit_ff;
  logic [7:0]  chunk_ff;
  logic [2:0]  chunkCnt_ff;
  logic [7:0]  sum_ff;
  logic        hdrStb_ff;
  logic        infStb_ff;
  logic        done_ff;
  logic        sigErr_ff;
  logic        fragErr_ff;

  ////////////////////////////////////////////////////////////////////
  // Word classification in the accepting cycle
  wire        inIdle    = state_ff == hbp_pkg::ST_IDLE;
  wire        accept    = cwValid & inIdle;
  wire        isHex     = cwType == hbp_pkg::HEX_TYPE;
  wire        isSec     = cwType == SEC_TYPE;
  wire        known     = isHex | isSec;
  wire [1:0]  idxNow    = cwStart ? 2'd0 : (wordIdx_ff == 2'd2) ? 2'd2 : wordIdx_ff + 2'd1;
  wire        isHdrWord = idxNow == 2'd0;
  wire        isInfWord = isHex & firstFrag_ff & (idxNow == 2'd1);
  wire        isData    = ~isHdrWord & ~isInfWord;
  wire [4:0]  limitNow  = cwLast ? fillEnd(cwData) : 5'(hbp_pkg::CW_BITS);
  wire        goShift   = accept & known & isData & (limitNow != 5'h00);
  wire        takeHdr   = accept & known & isHdrWord;

  // First word layout differs between hex and secure
  wire        cNow      = isHex ? cwData[hbp_pkg::HEX_C_POS] : cwData[hbp_pkg::SEC_C_POS];
  wire [1:0]  fNow      = isHex ? cwData[hbp_pkg::HEX_F_POS +: 2] : cwData[hbp_pkg::SEC_F_POS +: 2];
  wire [5:0]  nNow      = isHex ? cwData[hbp_pkg::HEX_N_POS +: 6] : cwData[hbp_pkg::SEC_N_POS +: 6];
  wire [11:0] kNow      = isHex ? cwData[11:0] : {2'b00, cwData[9:0]};
  wire        newMsg    = takeHdr & ~more_ff;

  ////////////////////////////////////////////////////////////////////
  // Bit-serial data path
  wire        bitNow    = word_ff[bitIdx_ff];
  wire [4:0]  charLen   = secure_ff ? 5'(hbp_pkg::SEC_CHAR_BITS) : info_ff.charBits;
  wire [15:0] charNow   = charAcc_ff | (16'(bitNow) << charBit_ff);
  wire        charFull  = {1'b0, charBit_ff} == charLen - 5'd1;
  wire        shifting  = state_ff == hbp_pkg::ST_SHIFT;
  // Full FIFO holds the shifter on a completed character
  wire        fifoInReady;
  wire        stall     = shifting & charFull & ~fifoInReady;
  wire        step      = shifting & ~stall;
  wire        lastBit   = bitIdx_ff == limit_ff - 5'd1;
  wire [7:0]  chunkNow  = chunk_ff | (8'(bitNow) << chunkCnt_ff);

  // Fragment end, from either state
  wire        endIdle   = accept & known & cwLast & ~goShift;
  wire        endShift  = step & lastBit & last_ff;
  wire        fragEnd   = endIdle | endShift;
  wire        contNow   = takeHdr ? cNow : hdr_ff.cont;
  wire        secEnd    = endIdle ? isSec : secure_ff;
  wire        msgEnd    = fragEnd & ~contNow;
  // Final bit has not reached the chunk register when the shift ends
  wire [7:0]  sumFinal  = sum_ff + (endShift ? chunkNow : chunk_ff);
  wire        sigBad    = ~sumFinal != info_ff.sig;

  wire        pushChar  = step & charFull;
  hbp_pkg::hbp_char_type pushData;
  assign pushData.secure = secure_ff;
  assign pushData.bits   = charNow;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= hbp_pkg::ST_IDLE;
    end else if (goShift) begin
      state_ff <= hbp_pkg::ST_SHIFT;
    end else if (step & lastBit) begin
      state_ff <= hbp_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      word_ff    <= '0;
      limit_ff   <= '0;
      bitIdx_ff  <= '0;
      last_ff    <= 1'b0;
      secure_ff  <= 1'b0;
      wordIdx_ff <= '0;
    end else if (accept) begin
      word_ff    <= cwData;
      limit_ff   <= limitNow;
      bitIdx_ff  <= '0;
      last_ff    <= cwLast;
      secure_ff  <= isSec;
      wordIdx_ff <= idxNow;
    end else if (step) begin
      bitIdx_ff  <= bitIdx_ff + 5'd1;
    end
  end

  // Header and fragment tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      hdr_ff       <= '0;
      firstFrag_ff <= 1'b1;
      expFrag_ff   <= '0;
    end else if (takeHdr) begin
      hdr_ff       <= '{kNow, cNow, fNow, nNow};
      firstFrag_ff <= ~more_ff;
      expFrag_ff   <= (fNow == 2'd2) ? 2'd0 : fNow + 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      more_ff <= 1'b0;
    end else if (fragEnd) begin
      more_ff <= contNow;
    end
  end

  // Reserved bits between B and S are skipped
  always_ff @(posedge clk) begin
    if (srst) begin
      info_ff <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 5'h01, 8'h00};
    end else if (accept & isInfWord) begin
      info_ff.numbered    <= cwData[hbp_pkg::INF_R_POS];
      info_ff.mailDrop    <= cwData[hbp_pkg::INF_M_POS];
      info_ff.rightToLeft <= cwData[hbp_pkg::INF_D_POS] & (cwData[hbp_pkg::INF_B_POS +: 4] != hbp_pkg::BLK_DEFAULT);
      info_ff.header      <= cwData[hbp_pkg::INF_H_POS];
      info_ff.transparent <= cwData[hbp_pkg::INF_B_POS +: 4] == hbp_pkg::BLK_DEFAULT;
      info_ff.charBits    <= blkLen(cwData[hbp_pkg::INF_B_POS +: 4]);
      info_ff.sig         <= cwData[hbp_pkg::INF_S_POS +: 8];
    end else if (newMsg) begin
      info_ff.charBits    <= blkLen(hbp_pkg::BLK_DEFAULT);
    end
  end

  // Partial characters are dropped at each fragment end
  always_ff @(posedge clk) begin
    if (srst | fragEnd | takeHdr) begin
      charAcc_ff <= '0;
      charBit_ff <= '0;
    end else if (step) begin
      charAcc_ff <= charFull ? 16'h0000 : charNow;
      charBit_ff <= charFull ? 4'h0 : charBit_ff + 4'h1;
    end
  end

  // Chunks run on across fragments: the sum covers the whole message
  always_ff @(posedge clk) begin
    if (srst | newMsg | msgEnd) begin
      chunk_ff    <= '0;
      chunkCnt_ff <= '0;
      sum_ff      <= '0;
    end else if (step & ~secure_ff) begin
      chunk_ff    <= (chunkCnt_ff == 3'd7) ? 8'h00 : chunkNow;
      chunkCnt_ff <= chunkCnt_ff + 3'd1;
      if (chunkCnt_ff == 3'd7) sum_ff <= sum_ff + chunkNow;
    end
  end

  // Event pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      hdrStb_ff  <= 1'b0;
      infStb_ff  <= 1'b0;
      done_ff    <= 1'b0;
      sigErr_ff  <= 1'b0;
      fragErr_ff <= 1'b0;
    end else begin
      hdrStb_ff  <= takeHdr;
      infStb_ff  <= accept & isInfWord;
      done_ff    <= msgEnd;
      sigErr_ff  <= msgEnd & ~secEnd & sigBad;
      fragErr_ff <= takeHdr & more_ff & (fNow != expFrag_ff);
    end
  end

  assign cwReady    = inIdle;
  assign hdr        = hdr_ff;
  assign info       = info_ff;
  assign hdrStrobe  = hdrStb_ff;
  assign infoStrobe = infStb_ff;
  assign msgDone    = done_ff;
  assign sigError   = sigErr_ff;
  assign fragError  = fragErr_ff;
  assign expectMore = more_ff;

  ////////////////////////////////////////////////////////////////////
  hbp_fifo #(
    .WIDTH ($bits(hbp_pkg::hbp_char_type)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .inValid  (pushChar),
    .inReady  (fifoInReady),
    .inData   (pushData),
    .outValid (chValid),
    .outReady (chReady),
    .outData  (chData)
  );
endmodule

// ===== design/hbp_pkg.sv
// Constants, field layouts and carrier types of the hex/binary message parser
// How it works
// - Characters of one to sixteen bits accepted
// - Fragment ends at last full character
// - Fill bits are inverse of last bit
// - Constant extra codeword marks exact fill
// - First word holds checksum, flag, numbers
// - Continued flag means more fragments follow
// - Fragment number counts modulo three
// - Header flag marks displayable header tag
// - Info fields only from first fragment
// - Retrieval flag marks message as numbered
// - Reserved five bits carry no meaning
// - Mail-drop flag selects overwrite storage area
// - Direction bit honoured unless one-bit blocking
// - Blocking code gives bits per character
// - One-bit blocking means transparent binary data
// - Signature is inverted eight-bit chunk sum
// - Chunks in bit order, fill excluded
// - Secure data are seven-bit characters
// - Secure first word: ten-bit checksum, flag
// - Layout applies only to hex vector type
package hbp_pkg;
  localparam int CW_BITS = 21;
  localparam logic [2:0] HEX_TYPE = 3'h6;
  // Hex first word
  localparam int HEX_C_POS = 12;
  localparam int HEX_F_POS = 13;
  localparam int HEX_N_POS = 15;
  // Secure first word
  localparam int SEC_C_POS = 10;
  localparam int SEC_F_POS = 11;
  localparam int SEC_N_POS = 13;
  localparam int SEC_CHAR_BITS = 7;
  // Hex second word of first fragment
  localparam int INF_R_POS = 0;
  localparam int INF_M_POS = 1;
  localparam int INF_D_POS = 2;
  localparam int INF_H_POS = 3;
  localparam int INF_B_POS = 4;
  localparam int INF_S_POS = 13;
  localparam logic [3:0] BLK_DEFAULT = 4'h1;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } hbp_state_type;

  typedef struct packed {
    logic [11:0] cksum;
    logic        cont;
    logic [1:0]  frag;
    logic [5:0]  msgNum;
  } hbp_hdr_type;

  typedef struct packed {
    logic       numbered;
    logic       mailDrop;
    logic       rightToLeft;
    logic       header;
    logic       transparent;
    logic [4:0] charBits;
    logic [7:0] sig;
  } hbp_info_type;

  typedef struct packed {
    logic        secure;
    logic [15:0] bits;
  } hbp_char_type;
endpackage

// ===== verification/hbp_parser_asserts.sv
// Port assertions of the hex/binary message parser
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module hbp_parser_asserts #(
  parameter logic [2:0] SEC_TYPE = 3'h7
) (
  // Clock, reset, channel
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  cwValid,
  input wire logic                  cwReady,
  input wire logic [2:0]            cwType,
  input wire logic                  cwStart,
  // Decode results
  input wire logic                  hdrStrobe,
  input wire logic                  infoStrobe,
  input wire hbp_pkg::hbp_info_type info,
  input wire logic                  msgDone,
  input wire logic                  sigError,
  input wire logic                  fragError,
  input wire logic                  expectMore,
  // Character output
  input wire logic                  chValid,
  input wire logic                  chReady,
  input wire hbp_pkg::hbp_char_type chData
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire hdrWord = cwValid && cwReady && cwStart;
  wire known   = cwType == hbp_pkg::HEX_TYPE || cwType == SEC_TYPE;
  property p_hdr; hdrWord && known |=> hdrStrobe && cwReady; endproperty
  a_hdr: assert property (p_hdr) else $error("header word not decoded");
  property p_drop; hdrWord && !known |=> !hdrStrobe; endproperty
  a_drop: assert property (p_drop) else $error("foreign word decoded");
  property p_sig; sigError |-> msgDone; endproperty
  a_sig: assert property (p_sig) else $error("signature error outside message end");
  property p_frag; fragError |-> hdrStrobe; endproperty
  a_frag: assert property (p_frag) else $error("fragment error without header");
  property p_more; $rose(expectMore) |-> !msgDone; endproperty
  a_more: assert property (p_more) else $error("message ended while more expected");
  property p_bits; infoStrobe |-> info.charBits inside {[5'h01:5'h10]}; endproperty
  a_bits: assert property (p_bits) else $error("character width out of range");
  property p_tr; infoStrobe |-> info.transparent == (info.charBits == 5'h01) && !(info.transparent && info.rightToLeft);
  endproperty
  a_tr: assert property (p_tr) else $error("transparent or direction wrong");
  property p_fifo; chValid && !chReady |=> chValid && $stable(chData); endproperty
  a_fifo: assert property (p_fifo) else $error("character lost while stalled");
  c_done: cover property (msgDone && !sigError);
  c_sig: cover property (sigError);
  c_frag: cover property (fragError);
endmodule
bind hbp_parser hbp_parser_asserts #(.SEC_TYPE(SEC_TYPE)) hbp_parser_asserts_inst (
  .clk(clk), .srst(srst), .cwValid(cwValid), .cwReady(cwReady), .cwType(cwType), .cwStart(cwStart),
  .hdrStrobe(hdrStrobe), .infoStrobe(infoStrobe), .info(info), .msgDone(msgDone), .sigError(sigError),
  .fragError(fragError), .expectMore(expectMore), .chValid(chValid), .chReady(chReady), .chData(chData));

// ===== verification/hbp_channel_model.sv
// Channel model offering codewords to the parser
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module hbp_channel_model (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Idle cycles after each taken word
  input wire logic [3:0]  gap,
  // Codewords
  output logic            cwValid,
  input wire logic        cwReady,
  output logic [20:0]     cwData,
  output logic [2:0]      cwType,
  output logic            cwStart,
  output logic            cwLast
);
  logic [25:0] q[$];
  logic [3:0]  waitCnt;
  logic        pending;
  initial begin
    {cwType, cwStart, cwLast, cwData} = 26'h0000000;
    cwValid = 1'b0;
    waitCnt = 4'h0;
    pending = 1'b0;
  end
  always @(posedge clk) begin
    // Sampled before the pop so the bench never sees a false idle
    pending <= q.size() != 0;
    if (srst) begin
      cwValid <= 1'b0;
    end else if (cwValid && cwReady && gap != 4'h0) begin
      cwValid <= 1'b0;
      cwData  <= ~cwData;
      waitCnt <= gap;
    end else if (!cwValid && waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
      cwData  <= ~cwData;
    end else if ((!cwValid || cwReady) && q.size() != 0) begin
      {cwType, cwStart, cwLast, cwData} <= q.pop_front();
      cwValid <= 1'b1;
    end else if (!cwValid || cwReady) begin
      // Released data alternates between the last word and its inverse
      cwValid <= 1'b0;
      cwData  <= ~cwData;
    end
  end
endmodule

// ===== verification/hbp_parser_bench.sv
// Self-checking bench of the hex/binary message parser
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module hbp_parser_bench;
  localparam logic [3:0] CODES [4] = '{4'h4, 4'h0, 4'h1, 4'hF};
  logic                  clk, srst, chReady, cwValid, cwReady, cwStart, cwLast;
  logic                  hdrStrobe, infoStrobe, msgDone, sigError, fragError, expectMore, chValid;
  logic [3:0]            gap;
  logic [20:0]           cwData;
  logic [2:0]            cwType;
  hbp_pkg::hbp_hdr_type  hdr;
  hbp_pkg::hbp_info_type info;
  hbp_pkg::hbp_char_type chData;
  int                    n_errors, checks_done, nDone, nSig, nFrag, nInfo, nHdr, k;
  hbp_parser #(.SEC_TYPE(3'h7), .DEPTH(32)) hbp_parser_inst (
    .clk(clk), .srst(srst), .cwValid(cwValid), .cwReady(cwReady), .cwData(cwData), .cwType(cwType),
    .cwStart(cwStart), .cwLast(cwLast), .hdr(hdr), .info(info), .hdrStrobe(hdrStrobe), .infoStrobe(infoStrobe),
    .msgDone(msgDone), .sigError(sigError), .fragError(fragError), .expectMore(expectMore),
    .chValid(chValid), .chReady(chReady), .chData(chData));
  hbp_channel_model hbp_channel_model_inst (
    .clk(clk), .srst(srst), .gap(gap), .cwValid(cwValid), .cwReady(cwReady), .cwData(cwData),
    .cwType(cwType), .cwStart(cwStart), .cwLast(cwLast));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (msgDone === 1'b1) nDone++;
    if (sigError === 1'b1) nSig++;
    if (fragError === 1'b1) nFrag++;
    if (infoStrobe === 1'b1) nInfo++;
    if (hdrStrobe === 1'b1) nHdr++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic clr();
    nDone = 0;
    nSig = 0;
    nFrag = 0;
    nInfo = 0;
    nHdr = 0;
  endtask
  function automatic logic [20:0] hw(input logic [11:0] c, input logic m, input logic [1:0] f, input logic [5:0] n);
    return {n, f, m, c};
  endfunction
  task automatic w(input logic [2:0] t, input logic s, input logic l, input logic [20:0] d);
    hbp_channel_model_inst.q.push_back({t, s, l, d});
  endtask
  // Waits until the channel is drained or the parser stalls for good
  task automatic run();
    int i;
    repeat (2) @(posedge clk);
    for (i = 0; i < 300 && (hbp_channel_model_inst.pending || cwValid || !cwReady); i++) @(posedge clk);
    check(i < 300, 1'b1);
    repeat (4) @(posedge clk);
  endtask
  task automatic pop(input logic [16:0] e);
    int i;
    for (i = 0; i < 60 && chValid !== 1'b1; i++) @(posedge clk);
    check(chValid, 1'b1);
    check(chData, e);
    chReady <= 1'b1;
    @(posedge clk);
    chReady <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fr(input logic [20:0] h, input logic hasInfo, input logic [20:0] inf);
    w(hbp_pkg::HEX_TYPE, 1'b1, 1'b0, h);
    if (hasInfo) w(hbp_pkg::HEX_TYPE, 1'b0, 1'b0, inf);
    w(hbp_pkg::HEX_TYPE, 1'b0, 1'b1, 21'h00A5C3);
    run();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_block(input logic [3:0] b, input logic [7:0] s);
    int bits;
    int j;
    bits = (b == 4'h0) ? 16 : int'(b);
    clr();
    fr(hw(12'hABC, 1'b0, 2'h0, 6'h15), 1'b1, {s, 5'h00, b, b[0], 3'h7});
    check(hdr, {12'hABC, 1'b0, 2'h0, 6'h15});
    check(info, {2'h3, b != 4'h1, b[0], b == 4'h1, 5'(bits), s});
    check(nDone, 1);
    check(nSig, int'(s != 8'h97));
    for (j = 0; j < 16 / bits; j++) pop({1'b0, 16'((32'hA5C3 >> (j * bits)) & ((32'h1 << bits) - 1))});
    check(chValid, 1'b0);
  endtask
  task automatic t_frags();
    int j;
    clr();
    fr(hw(12'h001, 1'b1, 2'h2, 6'h07), 1'b1, {8'hC7, 5'h00, 8'h40});
    check(expectMore, 1'b1);
    check(nDone, 0);
    fr(hw(12'h002, 1'b1, 2'h0, 6'h07), 1'b0, 21'h000000);
    fr(hw(12'h003, 1'b0, 2'h1, 6'h07), 1'b0, 21'h000000);
    check(nFrag, 0);
    check(nHdr, 3);
    check(nInfo, 1);
    check(info.sig, 8'hC7);
    check(nDone, 1);
    check(nSig, 0);
    check(expectMore, 1'b0);
    // Skipped fragment count on a fresh message
    fr(hw(12'h004, 1'b1, 2'h0, 6'h08), 1'b1, {8'h00, 5'h00, 8'h40});
    fr(hw(12'h005, 1'b0, 2'h2, 6'h08), 1'b0, 21'h000000);
    check(nFrag, 1);
    check(nHdr, 5);
    for (j = 0; j < 20; j++) pop({13'h0000, 4'(16'hA5C3 >> (4 * (j % 4)))});
  endtask
  task automatic t_full();
    int j;
    clr();
    gap <= 4'h3;
    w(hbp_pkg::HEX_TYPE, 1'b1, 1'b0, hw(12'h123, 1'b0, 2'h1, 6'h2A));
    w(hbp_pkg::HEX_TYPE, 1'b0, 1'b0, {8'h01, 5'h00, 4'h1, 4'h0});
    w(hbp_pkg::HEX_TYPE, 1'b0, 1'b0, 21'h1FFFFF);
    w(hbp_pkg::HEX_TYPE, 1'b0, 1'b0, 21'h1FFFFF);
    w(hbp_pkg::HEX_TYPE, 1'b0, 1'b1, 21'h000000);
    // FIFO fills after 32 one-bit characters and the shifter must wait
    repeat (120) @(posedge clk);
    check(cwReady, 1'b0);
    check(info, {5'h01, 5'h01, 8'h01});
    check(nDone, 0);
    for (j = 0; j < 42; j++) pop(17'h00001);
    run();
    check(nDone, 1);
    check(nSig, 0);
    check(chValid, 1'b0);
    gap <= 4'h0;
  endtask
  task automatic t_secure();
    clr();
    w(3'h7, 1'b1, 1'b0, {2'h0, 6'h2D, 2'h1, 1'b0, 10'h2AB});
    w(3'h7, 1'b0, 1'b1, 21'h002141);
    run();
    w(3'h2, 1'b1, 1'b0, 21'h1FFFFF);
    run();
    check(hdr, {12'h2AB, 1'b0, 2'h1, 6'h2D});
    check(nDone, 1);
    check(nSig, 0);
    pop({1'b1, 16'h0041});
    pop({1'b1, 16'h0042});
    check(chValid, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #300us;
    n_errors++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    chReady = 1'b0;
    gap = 4'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(info, {5'h01, 5'h01, 8'h00});
    check(expectMore, 1'b0);
    for (k = 0; k < 4; k++) t_block(CODES[k], 8'h97);
    t_block(4'h4, 8'h96);
    t_frags();
    t_full();
    t_secure();
    end_of_test();
  end
endmodule
